// [core/bqt_ctrl.sv]
// bqt_ctrl: queue threshold control register and its full and start gating
`timescale 1ns/1ps

module bqt_ctrl
  import bqt_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [1:0]  cfg_be,
  input  wire logic [15:0] cfg_wdata,
  output logic      [15:0] cfg_rdata,
  // serial memory preload
  input  wire logic        rom_load,
  input  wire logic [15:0] rom_data,
  // cache line sizes in doublewords
  input  wire logic [7:0]  pri_cls,
  input  wire logic [7:0]  sec_cls,
  // queue levels in free doublewords
  input  wire logic [7:0]  dn_pw_free,
  input  wire logic [7:0]  up_pw_free,
  input  wire logic [7:0]  pri_rd_free,
  input  wire logic [7:0]  sec_rd_free,
  // posted writes offered on each bus
  input  wire logic        pri_pw_req,
  input  wire logic        sec_pw_req,
  output logic             pri_pw_accept,
  output logic             pri_pw_retry,
  output logic             sec_pw_accept,
  output logic             sec_pw_retry,
  // pending delayed memory reads
  input  wire logic        pri_rd_pend,
  input  wire logic [1:0]  pri_rd_cmd,
  input  wire logic        sec_rd_pend,
  input  wire logic [1:0]  sec_rd_cmd,
  output logic             pri_rd_start,
  output logic             sec_rd_start,
  // registered queue status
  output logic             dn_pw_full,
  output logic             up_pw_full,
  output logic             pri_rd_ok,
  output logic             sec_rd_ok
);

  // =====================================================================
  // control register
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [15:0] next_cfg_rdata;
  logic        hit;

  assign hit = cfg_addr[7:1] == BQT_CTRL_OFS[7:1];

  // serial preload wins over a same-cycle configuration write
  always_comb begin
    next_ctrl = ctrl;
    if (cfg_wr && hit) begin
      if (cfg_be[0]) next_ctrl[7:0]  = cfg_wdata[7:0];
      if (cfg_be[1]) next_ctrl[15:8] = cfg_wdata[15:8];
    end
    if (rom_load) next_ctrl = rom_data;
    next_cfg_rdata = (cfg_rd && hit) ? ctrl : 16'h0000;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ctrl      <= BQT_CTRL_RST;
      cfg_rdata <= 16'h0000;
    end else begin
      ctrl      <= next_ctrl;
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // =====================================================================
  // per-direction threshold evaluation
  bqt_dir_if dn ();
  bqt_dir_if up ();

  // downstream writes and primary reads both land on the secondary side
  assign dn.pw_half = ctrl[BQT_PWT_DN_BIT];
  assign dn.rd_code = ctrl[BQT_RDT_PRI_LSB +: 2];
  assign dn.cls     = sec_cls;
  assign dn.pw_free = dn_pw_free;
  assign dn.rd_free = pri_rd_free;
  assign dn.rd_cmd  = pri_rd_cmd;

  assign up.pw_half = ctrl[BQT_PWT_UP_BIT];
  assign up.rd_code = ctrl[BQT_RDT_SEC_LSB +: 2];
  assign up.cls     = pri_cls;
  assign up.pw_free = up_pw_free;
  assign up.rd_free = sec_rd_free;
  assign up.rd_cmd  = sec_rd_cmd;

  bqt_gate u_dn_gate (
    .d (dn.gate)
  );

  bqt_gate u_up_gate (
    .d (up.gate)
  );

  // =====================================================================
  // status flags, registered so bus decisions see a steady level
  logic next_dn_full;
  logic next_up_full;
  logic next_pri_ok;
  logic next_sec_ok;

  always_comb begin
    next_dn_full = dn.pw_full;
    next_up_full = up.pw_full;
    next_pri_ok  = dn.rd_ok;
    next_sec_ok  = up.rd_ok;
  end

  // reset leaves queues reported full and reads held until levels are sampled
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dn_pw_full <= 1'b1;
      up_pw_full <= 1'b1;
      pri_rd_ok  <= 1'b0;
      sec_rd_ok  <= 1'b0;
    end else begin
      dn_pw_full <= next_dn_full;
      up_pw_full <= next_up_full;
      pri_rd_ok  <= next_pri_ok;
      sec_rd_ok  <= next_sec_ok;
    end
  end

  // =====================================================================
  // bus answers
  always_comb begin
    pri_pw_retry  = pri_pw_req &&  dn_pw_full;
    pri_pw_accept = pri_pw_req && !dn_pw_full;
    sec_pw_retry  = sec_pw_req &&  up_pw_full;
    sec_pw_accept = sec_pw_req && !up_pw_full;
    pri_rd_start  = pri_rd_pend && pri_rd_ok;
    sec_rd_start  = sec_rd_pend && sec_rd_ok;
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic [7:0] chk_dn_need;
  logic [7:0] chk_pri_need;
  assign chk_dn_need  = (ctrl[0] && (sec_cls == 8'h08 || sec_cls == 8'h10 ||
                         sec_cls == 8'h20)) ? {1'b0, sec_cls[7:1]} : sec_cls;
  assign chk_pri_need = (ctrl[3:2] == 2'b11 || (ctrl[3:2] == 2'b10 && pri_rd_cmd != 2'b00
                         && pri_rd_cmd != 2'b11)) ? sec_cls : 8'h08;

  // upstream side mirrors the above with the primary bus line size
  logic [7:0] chk_up_need;
  logic [7:0] chk_sec_need;
  assign chk_up_need  = (ctrl[1] && (pri_cls == 8'h08 || pri_cls == 8'h10 ||
                         pri_cls == 8'h20)) ? {1'b0, pri_cls[7:1]} : pri_cls;
  assign chk_sec_need = (ctrl[5:4] == 2'b11 || (ctrl[5:4] == 2'b10 && sec_rd_cmd != 2'b00
                         && sec_rd_cmd != 2'b11)) ? pri_cls : 8'h08;

  sequence s_cfg_full_write;
    cfg_wr && hit && (cfg_be == 2'b11) && !rom_load;
  endsequence

  sequence s_rom_load;
    rom_load;
  endsequence

  // single byte lane writes, preload kept out so the lane result is unambiguous
  sequence s_cfg_low_write;
    cfg_wr && hit && (cfg_be == 2'b01) && !rom_load;
  endsequence

  sequence s_cfg_high_write;
    cfg_wr && hit && (cfg_be == 2'b10) && !rom_load;
  endsequence

  sequence s_cfg_hit_read;
    cfg_rd && hit;
  endsequence

  ctrl_reset_a: assert property ($rose(rstn) |-> ctrl == 16'h0000)
    else $error("control register not zero after reset");

  cfg_write_a: assert property (s_cfg_full_write |=> ctrl == $past(cfg_wdata))
    else $error("configuration write not stored");

  rom_load_a: assert property (s_rom_load |=> ctrl == $past(rom_data))
    else $error("serial preload not stored");

  dn_full_a: assert property (1'b1 |=> dn_pw_full == ($past(dn_pw_free) <
                                        $past(chk_dn_need)))
    else $error("downstream full flag wrong");

  dn_half_a: assert property ((ctrl[0] && sec_cls == 8'h10 && dn_pw_free == 8'h08)
                              |=> !dn_pw_full)
    else $error("half line threshold not applied");

  pri_retry_a: assert property (pri_pw_req && dn_pw_full
                                |-> pri_pw_retry && !pri_pw_accept)
    else $error("primary write accepted while full");

  sec_retry_a: assert property (sec_pw_req |-> (sec_pw_retry == up_pw_full)
                                && (sec_pw_accept == !up_pw_full))
    else $error("secondary write answer wrong");

  pri_read_a: assert property (1'b1 |=> pri_rd_ok == ($past(pri_rd_free) >=
                                        $past(chk_pri_need)))
    else $error("primary read gate wrong");

  ill_code_a: assert property ((ctrl[3:2] == 2'b01 && pri_rd_free == 8'h07
                                && !rom_load && !cfg_wr) |=> !pri_rd_ok)
    else $error("illegal code not treated as eight doublewords");

  sec_line_a: assert property ((ctrl[5:4] == 2'b11 && sec_rd_free < pri_cls)
                               |=> !sec_rd_ok)
    else $error("secondary read started without a free line");

  // =====================================================================
  // start and read gate checks
  // one edge of delay skips the reset value of the flags
  sec_start_a: assert property (1'b1 ##1 sec_rd_pend |-> sec_rd_start ==
                                ($past(sec_rd_free) >= $past(chk_sec_need)))
    else $error("secondary read start does not follow the threshold");

  pri_start_a: assert property (1'b1 ##1 pri_rd_pend |-> pri_rd_start ==
                                ($past(pri_rd_free) >= $past(chk_pri_need)))
    else $error("primary read start does not follow the threshold");

  sec_read_a: assert property (1'b1 |=> sec_rd_ok == ($past(sec_rd_free) >=
                                         $past(chk_sec_need)))
    else $error("secondary read gate wrong");

  sec_ill_a: assert property ((ctrl[5:4] == 2'b01 && sec_rd_free == 8'h07
                               && !rom_load && !cfg_wr) |=> !sec_rd_ok)
    else $error("illegal secondary code not treated as eight doublewords");

  pri_line_a: assert property ((ctrl[3:2] == 2'b10 && pri_rd_cmd == 2'b00
                                && pri_rd_free == 8'h08) |=> pri_rd_ok)
    else $error("plain read held back under the line code");

  // =====================================================================
  // write queue, byte lane and read data checks
  up_full_a: assert property (1'b1 |=> up_pw_full == ($past(up_pw_free) <
                                        $past(chk_up_need)))
    else $error("upstream full flag wrong");

  up_half_a: assert property ((ctrl[1] && pri_cls == 8'h20 && up_pw_free == 8'h10)
                              |=> !up_pw_full)
    else $error("upstream half line threshold not applied");

  dn_line_a: assert property ((!ctrl[0] && sec_cls == 8'h10 && dn_pw_free == 8'h0f)
                              |=> dn_pw_full)
    else $error("downstream queue not full below one line");

  up_line_a: assert property ((!ctrl[1] && pri_cls == 8'h20 && up_pw_free == 8'h1f)
                              |=> up_pw_full)
    else $error("upstream queue not full below one line");

  pri_accept_a: assert property (1'b1 ##1 pri_pw_req |-> pri_pw_accept ==
                                 ($past(dn_pw_free) >= $past(chk_dn_need)))
    else $error("primary write answer does not follow the queue level");

  sec_accept_a: assert property (1'b1 ##1 sec_pw_req |-> sec_pw_accept ==
                                 ($past(up_pw_free) >= $past(chk_up_need)))
    else $error("secondary write answer does not follow the queue level");

  // the lane not enabled must keep its old contents
  cfg_low_a: assert property (s_cfg_low_write |=> ctrl == {$past(ctrl[15:8]),
                              $past(cfg_wdata[7:0])})
    else $error("low byte write not stored alone");

  cfg_high_a: assert property (s_cfg_high_write |=> ctrl == {$past(cfg_wdata[15:8]),
                               $past(ctrl[7:0])})
    else $error("high byte write not stored alone");

  rd_data_a: assert property (s_cfg_hit_read |=> cfg_rdata == $past(ctrl))
    else $error("read data does not show the register");

  rd_idle_a: assert property (!(cfg_rd && hit) |=> cfg_rdata == 16'h0000)
    else $error("read data not cleared outside a read");

endmodule : bqt_ctrl

// [include/bqt_pkg.sv]
// bqt_pkg: offsets, field layout, reset value and threshold helpers
package bqt_pkg;

  // =====================================================================
  // register map
  localparam logic [7:0]  BQT_CTRL_OFS    = 8'hce;
  localparam logic [15:0] BQT_CTRL_RST    = 16'h0000;
  localparam int          BQT_PWT_DN_BIT  = 0;
  localparam int          BQT_PWT_UP_BIT  = 1;
  localparam int          BQT_RDT_PRI_LSB = 2;
  localparam int          BQT_RDT_SEC_LSB = 4;

  // =====================================================================
  // thresholds, all in doublewords
  localparam logic [7:0]  BQT_MIN_RD_DW   = 8'h08;
  localparam logic [7:0]  BQT_CLS_8       = 8'h08;
  localparam logic [7:0]  BQT_CLS_16      = 8'h10;
  localparam logic [7:0]  BQT_CLS_32      = 8'h20;

  typedef enum logic [1:0] {
    BQT_RD_CODE_8DW   = 2'b00,
    BQT_RD_CODE_ILL   = 2'b01,
    BQT_RD_CODE_LINE  = 2'b10,
    BQT_RD_CODE_ALL   = 2'b11
  } bqt_rdcode_e;

  typedef enum logic [1:0] {
    BQT_CMD_MR  = 2'b00,
    BQT_CMD_MRL = 2'b01,
    BQT_CMD_MRM = 2'b10,
    BQT_CMD_RSV = 2'b11
  } bqt_rdcmd_e;

  // free space a posted write queue must keep to count as not full
  function automatic logic [7:0] bqt_pw_need(input logic half, input logic [7:0] cls);
    logic half_ok;
    half_ok = (cls == BQT_CLS_8) || (cls == BQT_CLS_16) || (cls == BQT_CLS_32);
    return (half && half_ok) ? (cls >> 1) : cls;
  endfunction : bqt_pw_need

  // free space the read data queue needs before a memory read starts
  function automatic logic [7:0] bqt_rd_need(input logic [1:0] code, input logic [1:0] cmd,
                                             input logic [7:0] cls);
    logic line_cmd;
    line_cmd = (cmd == BQT_CMD_MRL) || (cmd == BQT_CMD_MRM);
    case (code)
      BQT_RD_CODE_LINE: return line_cmd ? cls : BQT_MIN_RD_DW;
      BQT_RD_CODE_ALL:  return cls;
      default:          return BQT_MIN_RD_DW;
    endcase
  endfunction : bqt_rd_need

endpackage : bqt_pkg

// [include/bqt_dir_if.sv]
// bqt_dir_if: settings and queue levels of one forwarding direction
`timescale 1ns/1ps
interface bqt_dir_if;
  logic       pw_half;
  logic [1:0] rd_code;
  logic [7:0] cls;
  logic [7:0] pw_free;
  logic [7:0] rd_free;
  logic [1:0] rd_cmd;
  logic       pw_full;
  logic       rd_ok;

  modport ctl  (output pw_half, rd_code, cls, pw_free, rd_free, rd_cmd,
                input  pw_full, rd_ok);
  modport gate (input  pw_half, rd_code, cls, pw_free, rd_free, rd_cmd,
                output pw_full, rd_ok);
endinterface : bqt_dir_if

// [core/bqt_gate.sv]
// bqt_gate: full and start decisions for one direction
`timescale 1ns/1ps
module bqt_gate
  import bqt_pkg::*;
(
  bqt_dir_if.gate d
);
  // =====================================================================
  // comparisons in doublewords
  always_comb begin
    d.pw_full = d.pw_free < bqt_pw_need(d.pw_half, d.cls);
    d.rd_ok   = d.rd_free >= bqt_rd_need(d.rd_code, d.rd_cmd, d.cls);
  end
endmodule : bqt_gate

// [verif/bqt_far_model.sv]
// bqt_far_model: bus agents and queue levels on both sides of the bridge
`timescale 1ns/1ps
module bqt_far_model (
  input  wire logic       sys_clk,
  output logic      [7:0] pri_cls,
  output logic      [7:0] sec_cls,
  output logic      [7:0] dn_pw_free,
  output logic      [7:0] up_pw_free,
  output logic      [7:0] pri_rd_free,
  output logic      [7:0] sec_rd_free,
  output logic            pri_pw_req,
  output logic            sec_pw_req,
  output logic            pri_rd_pend,
  output logic      [1:0] pri_rd_cmd,
  output logic            sec_rd_pend,
  output logic      [1:0] sec_rd_cmd
);
  initial begin
    {pri_cls, sec_cls, dn_pw_free, up_pw_free, pri_rd_free, sec_rd_free} = '0;
    {pri_pw_req, sec_pw_req, pri_rd_pend, sec_rd_pend, pri_rd_cmd, sec_rd_cmd} = '0;
  end
  // =====================================================================
  // agents change levels just after the falling edge
  task automatic set_lv(input logic [7:0] pc, input logic [7:0] sc, input logic [7:0] f0,
                        input logic [7:0] f1, input logic [1:0] cmd);
    @(negedge sys_clk);
    pri_cls = pc;
    sec_cls = sc;
    {dn_pw_free, pri_rd_free} = {f0, f0};
    {up_pw_free, sec_rd_free} = {f1, f1};
    {pri_pw_req, sec_pw_req, pri_rd_pend, sec_rd_pend} = 4'hf;
    {pri_rd_cmd, sec_rd_cmd} = {cmd, cmd};
  endtask : set_lv
endmodule : bqt_far_model

// [verif/bridge_queue_threshold_ctrl_tb.sv]
// bridge_queue_threshold_ctrl_tb: register access and queue gating checks
`timescale 1ns/1ps
module bridge_queue_threshold_ctrl_tb;
  import bqt_pkg::*;
  logic sys_clk = 1'b0, rstn = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, rom_load = 1'b0;
  logic [7:0] cfg_addr = 8'h00, pc, sc, pcl, scl, f0, f1, cl [4];
  logic [1:0] cfg_be = 2'h0, p_cmd, s_cmd;
  logic [15:0] cfg_wdata = 16'h0000, rom_data = 16'h0000, cfg_rdata, rd;
  logic [7:0] dnf, upf, prf, srf;
  logic p_req, s_req, p_pend, s_pend, p_acc, p_rty, s_acc, s_rty, p_st, s_st;
  logic dn_full, up_full, p_ok, s_ok;
  int bad_count = 0, n_compared = 0;
  always #10 sys_clk = ~sys_clk;
  bqt_far_model far (.sys_clk(sys_clk), .pri_cls(pc), .sec_cls(sc), .dn_pw_free(dnf),
    .up_pw_free(upf), .pri_rd_free(prf), .sec_rd_free(srf), .pri_pw_req(p_req),
    .sec_pw_req(s_req), .pri_rd_pend(p_pend), .pri_rd_cmd(p_cmd), .sec_rd_pend(s_pend),
    .sec_rd_cmd(s_cmd));
  bqt_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .rom_load(rom_load), .rom_data(rom_data), .pri_cls(pc), .sec_cls(sc),
    .dn_pw_free(dnf), .up_pw_free(upf), .pri_rd_free(prf), .sec_rd_free(srf),
    .pri_pw_req(p_req), .sec_pw_req(s_req), .pri_pw_accept(p_acc), .pri_pw_retry(p_rty),
    .sec_pw_accept(s_acc), .sec_pw_retry(s_rty), .pri_rd_pend(p_pend),
    .pri_rd_cmd(p_cmd), .sec_rd_pend(s_pend), .sec_rd_cmd(s_cmd), .pri_rd_start(p_st),
    .sec_rd_start(s_st), .dn_pw_full(dn_full), .up_pw_full(up_full), .pri_rd_ok(p_ok),
    .sec_rd_ok(s_ok));
  // =====================================================================
  // access tasks and comparisons
  task automatic cfg_write(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(negedge sys_clk);
    {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
    @(negedge sys_clk);
    cfg_wr = 1'b0;
  endtask : cfg_write
  task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
    @(negedge sys_clk);
    {cfg_rd, cfg_addr} = {1'b1, a};
    @(negedge sys_clk);
    cfg_rd = 1'b0;
    d = cfg_rdata;
  endtask : cfg_read
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: register read %h, expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask : chk1
  function automatic logic [7:0] pw_need(input logic h, input logic [7:0] c);
    return (h && (c == 8'h08 || c == 8'h10 || c == 8'h20)) ? {1'b0, c[7:1]} : c;
  endfunction : pw_need
  function automatic logic [7:0] rd_need(input logic [1:0] k, input logic [1:0] m,
                                         input logic [7:0] c);
    if (k == 2'b11 || (k == 2'b10 && (m == 2'b01 || m == 2'b10))) return c;
    return 8'h08;
  endfunction : rd_need
  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // =====================================================================
  // test sequence
  initial begin
    cl = '{8'h08, 8'h10, 8'h20, 8'h0c};
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    cfg_read(BQT_CTRL_OFS, rd);
    chk16(rd, 16'h0000);
    cfg_read(8'hcc, rd);
    chk16(rd, 16'h0000);
    cfg_write(8'hce, 2'b11, 16'h1234);
    cfg_read(8'hce, rd);
    chk16(rd, 16'h1234);
    cfg_write(8'hcf, 2'b10, 16'hff00);
    cfg_read(8'hcf, rd);
    chk16(rd, 16'hff34);
    @(negedge sys_clk);
    {rom_load, rom_data} = {1'b1, 16'h0035};
    @(negedge sys_clk);
    rom_load = 1'b0;
    cfg_read(8'hce, rd);
    chk16(rd, 16'h0035);
    $display("test register access done");
    for (int i = 0; i < 4; i++) for (int h = 0; h < 2; h++) for (int k = 0; k < 2; k++) begin
      {scl, pcl} = {cl[i], cl[(i + 1) % 4]};
      cfg_write(BQT_CTRL_OFS, 2'b01, {14'h0000, h[0], h[0]});
      far.set_lv(pcl, scl, pw_need(h[0], scl) - 8'h01 + 8'(k),
                 pw_need(h[0], pcl) - 8'h01 + 8'(k), 2'b00);
      @(negedge sys_clk);
      chk1(dn_full, k == 0);
      chk1(p_rty, k == 0);
      chk1(p_acc, k != 0);
      chk1(up_full, k == 0);
      chk1(s_rty, k == 0);
      chk1(s_acc, k != 0);
    end
    $display("test posted write thresholds done");
    for (int c = 0; c < 4; c++) for (int m = 0; m < 4; m++) for (int k = 0; k < 2; k++) begin
      cfg_write(BQT_CTRL_OFS, 2'b01, {10'h000, c[1:0], c[1:0], 2'b00});
      f0 = rd_need(c[1:0], m[1:0], 8'h20) - 8'h01 + 8'(k);
      f1 = rd_need(c[1:0], m[1:0], 8'h10) - 8'h01 + 8'(k);
      far.set_lv(8'h10, 8'h20, f0, f1, m[1:0]);
      @(negedge sys_clk);
      chk1(p_ok, k != 0);
      chk1(p_st, k != 0);
      chk1(s_ok, k != 0);
      chk1(s_st, k != 0);
    end
    $display("test read thresholds done");
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    cfg_read(BQT_CTRL_OFS, rd);
    chk16(rd, BQT_CTRL_RST);
    $display("test mid-run reset done");
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    finish_test();
  end
endmodule : bridge_queue_threshold_ctrl_tb
